/* File: dv/card_specific_data_register_tb_top.sv */
// Self-checking bench for the card descriptor bank
`timescale 1ns/1ps
`default_nettype none
module card_specific_data_register_tb_top;
  localparam logic [21:0] CAP = 22'h15_A5C3;  // Part size chosen for the run
  logic         clock_i;
  logic         rst_n_i;
  logic         sd_clk;
  logic         sd_cmd;
  logic         sd_dat0;
  logic         card_cmd;
  logic         card_oe;
  logic [127:0] image;
  logic [15:0]  card_addr;
  logic         prog_err;
  logic         inact;
  logic         ready;
  logic [135:0] resp;
  logic         hit;
  int           failures;
  int           tests_run;

  csd_register_bank #(.CAPACITY(CAP)) csd_register_bank_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sd_clk_i(sd_clk), .sd_cmd_i(sd_cmd),
    .sd_dat0_i(sd_dat0), .sd_cmd_o(card_cmd), .sd_cmd_oe_o(card_oe), .csd_o(image),
    .rca_o(card_addr), .program_error_o(prog_err), .inactive_o(inact), .ready_o(ready));

  host_link_model host_link_model_inst (
    .clock_i(clock_i), .card_cmd_i(card_cmd), .card_oe_i(card_oe),
    .sd_clk_o(sd_clk), .sd_cmd_o(sd_cmd), .sd_dat0_o(sd_dat0));

  // 10 MHz bench clock
  initial clock_i = 1'h0;
  always #50 clock_i = ~clock_i;

  // Expected image, built field by field from the layout
  function automatic logic [127:0] img(input logic cp, input logic pm, input logic tp,
                                       input logic [6:0] crc);
    img = {2'h1, 6'h00, 8'h0E, 8'h00, 8'h32, 12'h5B5, 4'h9, 4'h0, 6'h00, CAP, 2'h1,
           7'h7F, 7'h00, 1'h0, 2'h0, 3'h2, 4'h9, 1'h0, 5'h00, 1'h0, cp, pm, tp,
           4'h0, crc, 1'h1};
  endfunction

  task automatic chk_img(input logic [127:0] got, input logic [127:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_half(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Reset stands for a power cycle, held three cycles
  task automatic do_reset();
    rst_n_i = 1'h0;
    repeat (3) @(posedge clock_i);
    #1;
    rst_n_i = 1'h1;
  endtask

  // Fixed fields, capacity, cleared writable bits, line released
  task automatic t_reset_values();
    chk_img(image, img(1'h0, 1'h0, 1'h0, 7'h00));
    chk_half(image[31:16], 16'h0A40);
    chk_half(image[15:0], 16'h0001);
    chk_bit(image[76], 1'h0);
    chk_bit(image[46], 1'h1);
    chk_half(card_addr, 16'h0000);
    chk_bit(card_oe, 1'h0);
    chk_bit(prog_err, 1'h0);
    chk_bit(inact, 1'h0);
    chk_bit(ready, 1'h0);
  endtask

  // One clock short of the wake run must not be enough
  task automatic t_wake();
    host_link_model_inst.wake(73);
    chk_bit(ready, 1'h0);
    host_link_model_inst.wake(2);
    chk_bit(ready, 1'h1);
  endtask

  // Read: header then the whole image msb first, line released after
  task automatic t_read(input logic [127:0] exp);
    host_link_model_inst.send_cmd(6'h09, 32'h0000_0000);
    host_link_model_inst.get_resp(resp, hit);
    chk_bit(hit, 1'h1);
    chk_half({8'h00, resp[135:128]}, 16'h003F);
    chk_img(resp[127:0], exp);
    chk_bit(card_oe, 1'h0);
  endtask

  // Two addresses back to back; lower argument half must be ignored
  task automatic t_addr();
    logic [15:0] a;
    for (int i = 0; i < 2; i++)
    begin
      a = (i == 0) ? 16'hA5C3 : 16'h5A3C;
      host_link_model_inst.send_cmd(6'h03, {a, 16'hFFFF});
      host_link_model_inst.wake(2);
      chk_half(card_addr, a);
    end
  endtask

  // Shared program step: send image, judge stored image and error flag
  task automatic t_prog(input logic [127:0] v, input logic [127:0] exp, input logic err);
    host_link_model_inst.send_cmd(6'h1B, 32'h0000_0000);
    host_link_model_inst.send_data(v);
    chk_img(image, exp);
    chk_bit(prog_err, err);
  endtask

  // Writable fields, one-time bits set once, then turned back
  task automatic t_prog_fields();
    logic [127:0] a;
    logic [127:0] b;
    a = img(1'h0, 1'h0, 1'h1, 7'h55);
    b = img(1'h1, 1'h1, 1'h0, 7'h2A);
    t_prog(a, a, 1'h0);
    t_read(a);
    t_prog(b, b, 1'h0);
    t_prog(b, b, 1'h0);
    t_prog(img(1'h0, 1'h1, 1'h0, 7'h2A), b, 1'h1);
    t_prog(img(1'h1, 1'h0, 1'h0, 7'h2A), b, 1'h1);
  endtask

  // One read-only bit flipped with a legal change; whole update refused
  task automatic t_prog_ro();
    logic [127:0] b;
    logic [127:0] v;
    int           pos [11];
    b = img(1'h1, 1'h1, 1'h0, 7'h2A);
    pos = '{127, 115, 100, 90, 81, 76, 60, 46, 31, 27, 0};
    for (int i = 0; i < 11; i++)
    begin
      v = b ^ (128'h1 << pos[i]) ^ (128'h1 << 12);
      t_prog(v, b, 1'h1);
    end
    t_prog(b, b, 1'h0);
  endtask

  // Inactive card ignores everything until power is cycled
  task automatic t_inactive();
    host_link_model_inst.send_cmd(6'h0F, 32'h0000_0000);
    host_link_model_inst.wake(2);
    chk_bit(inact, 1'h1);
    host_link_model_inst.send_cmd(6'h09, 32'h0000_0000);
    host_link_model_inst.get_resp(resp, hit);
    chk_bit(hit, 1'h0);
    host_link_model_inst.send_cmd(6'h03, 32'h1234_0000);
    host_link_model_inst.wake(2);
    chk_half(card_addr, 16'h5A3C);
    host_link_model_inst.power_down();
    do_reset();
    host_link_model_inst.power_up();
    t_reset_values();
    host_link_model_inst.wake(74);
    t_read(img(1'h0, 1'h0, 1'h0, 7'h00));
  endtask

  // Watchdog: a hung link ends the run as a mismatch
  initial
  begin
    repeat (100000) @(posedge clock_i);
    failures++;
    final_report();
  end

  // Main sequence
  initial
  begin
    failures = 0;
    tests_run = 0;
    rst_n_i = 1'h0;
    do_reset();
    t_reset_values();
    t_wake();
    t_read(img(1'h0, 1'h0, 1'h0, 7'h00));
    t_addr();
    t_prog_fields();
    t_prog_ro();
    t_inactive();
    final_report();
  end
endmodule
`default_nettype wire

/* File: dv/host_link_model.sv */
// Host-side model of the card link: clock, command and data line driver
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  input  wire logic clock_i,     // Bench clock, aligns every link edge
  input  wire logic card_cmd_i,  // Value the card drives on command
  input  wire logic card_oe_i,   // Card drives the command line
  output logic      sd_clk_o,    // Card clock pin
  output logic      sd_cmd_o,    // Resolved command line level
  output var logic  sd_dat0_o    // Data line 0
);
  logic host_on;
  logic host_cmd;

  // Pull-up wins when neither side drives the line
  assign sd_cmd_o = card_oe_i ? card_cmd_i : (host_on ? host_cmd : 1'h1);

  // Lines idle high, clock parked low until the first tick
  initial
  begin
    sd_clk_o  = 1'h0;
    sd_dat0_o = 1'h1;
    host_on   = 1'h1;
    host_cmd  = 1'h1;
  end

  // One card clock of 8 bench cycles; s is the line level just before the fall
  task automatic tick(input logic c, input logic d, output logic s);
    @(posedge clock_i);
    #1;
    s = sd_cmd_o;
    sd_clk_o  = 1'h0;
    host_cmd  = c;
    sd_dat0_o = d;
    repeat (4) @(posedge clock_i);
    #1;
    sd_clk_o = 1'h1;
    repeat (3) @(posedge clock_i);
  endtask

  // Idle clocks with command held high
  task automatic wake(input int n);
    logic s;
    repeat (n) tick(1'h1, 1'h1, s);
  endtask

  // Frame: start, direction, index, argument, unchecked check bits, end
  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    logic        s;
    f = {2'h1, idx, arg, 7'h00, 1'h1};
    host_on = 1'h1;
    for (int i = 47; i >= 0; i--) tick(f[i], 1'h1, s);
  endtask

  // Line released; each bit is read one clock late, where it is settled
  task automatic get_resp(output logic [135:0] r, output logic hit);
    logic s;
    host_on = 1'h0;
    hit = 1'h0;
    r = 136'h0;
    for (int j = 0; j < 139; j++)
    begin
      tick(1'h1, 1'h1, s);
      hit = hit | card_oe_i;
      if (j > 0 && j < 137) r = {r[134:0], s};
    end
    host_on = 1'h1;
  endtask

  // Start bit on data line 0, then the image msb first
  task automatic send_data(input logic [127:0] img);
    logic s;
    tick(1'h1, 1'h0, s);
    for (int i = 127; i >= 0; i--) tick(1'h1, img[i], s);
    repeat (2) tick(1'h1, 1'h1, s);
  endtask

  // All link lines driven low while supply is off, so no pin current flows
  task automatic power_down();
    @(posedge clock_i);
    #1;
    sd_clk_o  = 1'h0;
    host_cmd  = 1'h0;
    sd_dat0_o = 1'h0;
  endtask

  // Lines back to idle once supply returns
  task automatic power_up();
    host_cmd  = 1'h1;
    sd_dat0_o = 1'h1;
  endtask
endmodule
`default_nettype wire

/* File: logic/csd_register_bank.sv */
// Card descriptor and address registers behind the card command link
`timescale 1ns/1ps
`default_nettype none
module csd_register_bank #(
  parameter logic [21:0] CAPACITY = 22'h00_0FFF
) (
  input  wire logic         clock_i,          // Block clock, 10 MHz
  input  wire logic         rst_n_i,          // Async reset (power cycle), active low
  input  wire logic         sd_clk_i,         // Host card clock pin
  input  wire logic         sd_cmd_i,         // Command line, input side
  input  wire logic         sd_dat0_i,        // Data line 0, input only
  output logic              sd_cmd_o,         // Command line, driven value
  output logic              sd_cmd_oe_o,      // Command line drive enable
  output logic      [127:0] csd_o,            // Current descriptor image
  output logic      [15:0]  rca_o,            // Relative card address
  output logic              program_error_o,  // Last program was rejected
  output logic              inactive_o,       // Card has gone inactive
  output logic              ready_o           // Wake-up clocks seen
);

  logic [2:0]  pin_lvl;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cmd_lvl;
  logic        dat_lvl;

  sd_csd_pkg::link_state_e state_ff;
  sd_csd_pkg::link_state_e nxt_state;

  logic [7:0]   wake_cnt_ff;
  logic [7:0]   bit_cnt_ff;
  logic [46:0]  cmd_sr_ff;
  logic [126:0] data_sr_ff;
  logic [135:0] resp_sr_ff;
  logic [127:0] csd_ff;
  logic [15:0]  rca_ff;
  logic         err_ff;
  logic         inactive_ff;
  logic         ready_ff;
  logic         cmd_out_ff;
  logic         cmd_oe_ff;

  logic [47:0]  frame;
  logic         frame_done;
  logic         frame_ok;
  logic [5:0]   cmd_index;
  logic [15:0]  arg_hi;
  logic [127:0] new_img;
  logic         prog_done;
  logic         prog_ok;
  logic         resp_end;

  // Power-up image folded to a constant, so the async reset loads no live logic
  localparam logic [127:0] RESET_IMG = sd_csd_pkg::build_csd(
    CAPACITY, sd_csd_pkg::RESET_COPY, sd_csd_pkg::RESET_PERM, sd_csd_pkg::RESET_TMP,
    sd_csd_pkg::RESET_CRC);

  // Pins cross into the block clock before anything reads them
  pin_sampler #(
    .W (3)
  ) u_sampler (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .pin_i   ({sd_dat0_i, sd_cmd_i, sd_clk_i}),
    .level_o (pin_lvl),
    .rise_o  (sclk_rise),
    .fall_o  (sclk_fall)
  );

  assign cmd_lvl = pin_lvl[1];
  assign dat_lvl = pin_lvl[2];

  // Accept check: read-only bits unchanged, one-time bits never cleared again
  function automatic logic program_allowed(input logic [127:0] cur,
                                           input logic [127:0] img);
    logic ro_same;
    logic once_ok;
    ro_same = ((cur ^ img) & ~sd_csd_pkg::WR_MASK) == 128'h0;
    once_ok = !(cur[sd_csd_pkg::POS_COPY] && !img[sd_csd_pkg::POS_COPY]) &&
              !(cur[sd_csd_pkg::POS_PERM] && !img[sd_csd_pkg::POS_PERM]);
    program_allowed = ro_same && once_ok;
  endfunction

  // Frame decode on the last command bit; direction and end bits must be high
  assign frame      = {cmd_sr_ff, cmd_lvl};
  assign frame_done = (state_ff == sd_csd_pkg::ST_CMD) && sclk_rise &&
                      (bit_cnt_ff == sd_csd_pkg::CMD_FRAME_LAST);
  assign frame_ok   = frame[46] && frame[0];
  assign cmd_index  = frame[45:40];
  assign arg_hi     = frame[39:24];
  assign new_img    = {data_sr_ff, dat_lvl};
  assign prog_done  = (state_ff == sd_csd_pkg::ST_DATA) && sclk_rise &&
                      (bit_cnt_ff == sd_csd_pkg::DATA_LAST);
  assign prog_ok    = program_allowed(csd_ff, new_img);
  assign resp_end   = (state_ff == sd_csd_pkg::ST_RESP) && sclk_fall &&
                      (bit_cnt_ff == sd_csd_pkg::RESP_BITS);

  // Next link state
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      sd_csd_pkg::ST_WAKE:
        if (sclk_rise && cmd_lvl && wake_cnt_ff == sd_csd_pkg::WAKE_CYCLES - 8'h01)
          nxt_state = sd_csd_pkg::ST_IDLE;
      sd_csd_pkg::ST_IDLE:
        if (sclk_rise && !cmd_lvl)
          nxt_state = sd_csd_pkg::ST_CMD;
      sd_csd_pkg::ST_CMD:
        if (frame_done)
        begin
          if (frame_ok && cmd_index == sd_csd_pkg::CMD_SEND_CSD)
            nxt_state = sd_csd_pkg::ST_RESP;
          else if (frame_ok && cmd_index == sd_csd_pkg::CMD_PROGRAM)
            nxt_state = sd_csd_pkg::ST_DWAIT;
          else if (frame_ok && cmd_index == sd_csd_pkg::CMD_INACTIVE)
            nxt_state = sd_csd_pkg::ST_DEAD;
          else
            nxt_state = sd_csd_pkg::ST_IDLE;
        end
      sd_csd_pkg::ST_RESP:
        if (resp_end)
          nxt_state = sd_csd_pkg::ST_IDLE;
      sd_csd_pkg::ST_DWAIT:
        if (sclk_rise && !dat_lvl)
          nxt_state = sd_csd_pkg::ST_DATA;
      sd_csd_pkg::ST_DATA:
        if (prog_done)
          nxt_state = sd_csd_pkg::ST_IDLE;
      sd_csd_pkg::ST_DEAD:
        nxt_state = sd_csd_pkg::ST_DEAD;
      default:
        nxt_state = sd_csd_pkg::ST_WAKE;
    endcase
  end

  // State register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_ff <= sd_csd_pkg::ST_WAKE;
    else
      state_ff <= nxt_state;
  end

  // Wake-up clock count; a low command line restarts it
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wake_cnt_ff <= 8'h00;
    else if (state_ff == sd_csd_pkg::ST_WAKE && sclk_rise)
      wake_cnt_ff <= cmd_lvl ? wake_cnt_ff + 8'h01 : 8'h00;
  end

  // Bit counter shared by command, response and data phases
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bit_cnt_ff <= 8'h00;
    else if (state_ff != nxt_state)
      bit_cnt_ff <= (nxt_state == sd_csd_pkg::ST_CMD) ? 8'h01 : 8'h00;
    else if (sclk_rise && (state_ff == sd_csd_pkg::ST_CMD ||
                           state_ff == sd_csd_pkg::ST_DATA))
      bit_cnt_ff <= bit_cnt_ff + 8'h01;
    else if (sclk_fall && state_ff == sd_csd_pkg::ST_RESP)
      bit_cnt_ff <= bit_cnt_ff + 8'h01;
  end

  // Command and data shift registers, sampled on card clock rise
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_sr_ff  <= '0;
      data_sr_ff <= '0;
    end
    else if (sclk_rise)
    begin
      if (state_ff == sd_csd_pkg::ST_IDLE || state_ff == sd_csd_pkg::ST_CMD)
        cmd_sr_ff <= {cmd_sr_ff[45:0], cmd_lvl};
      if (state_ff == sd_csd_pkg::ST_DATA)
        data_sr_ff <= {data_sr_ff[125:0], dat_lvl};
    end
  end

  // Descriptor store; fixed fields rebuilt so only writable bits can change
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      csd_ff <= RESET_IMG;
    else if (prog_done && prog_ok)
      csd_ff <= sd_csd_pkg::build_csd(CAPACITY, new_img[sd_csd_pkg::POS_COPY],
                                      new_img[sd_csd_pkg::POS_PERM],
                                      new_img[sd_csd_pkg::POS_TMP],
                                      new_img[sd_csd_pkg::POS_CRC_HI:
                                              sd_csd_pkg::POS_CRC_LO]);
  end

  // Error flag holds until the next program completes
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      err_ff <= 1'h0;
    else if (prog_done)
      err_ff <= !prog_ok;
  end

  // Relative card address, loaded from the upper argument half
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rca_ff <= sd_csd_pkg::RESET_RCA;
    else if (frame_done && frame_ok && cmd_index == sd_csd_pkg::CMD_SET_ADDR)
      rca_ff <= arg_hi;
  end

  // Inactive and ready status; only reset clears inactive
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      inactive_ff <= 1'h0;
      ready_ff    <= 1'h0;
    end
    else
    begin
      if (nxt_state == sd_csd_pkg::ST_DEAD)
        inactive_ff <= 1'h1;
      if (nxt_state != sd_csd_pkg::ST_WAKE)
        ready_ff <= 1'h1;
    end
  end

  // Long response shifted out on card clock fall, so host samples on rise
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      resp_sr_ff <= '0;
      cmd_out_ff <= 1'h1;
      cmd_oe_ff  <= 1'h0;
    end
    else if (frame_done && nxt_state == sd_csd_pkg::ST_RESP)
      resp_sr_ff <= {sd_csd_pkg::RESP_HEADER, csd_ff};
    else if (resp_end)
    begin
      cmd_out_ff <= 1'h1;
      cmd_oe_ff  <= 1'h0;
    end
    else if (state_ff == sd_csd_pkg::ST_RESP && sclk_fall)
    begin
      cmd_out_ff <= resp_sr_ff[135];
      cmd_oe_ff  <= 1'h1;
      resp_sr_ff <= {resp_sr_ff[134:0], 1'h1};
    end
  end

  assign sd_cmd_o        = cmd_out_ff;
  assign sd_cmd_oe_o     = cmd_oe_ff;
  assign csd_o           = csd_ff;
  assign rca_o           = rca_ff;
  assign program_error_o = err_ff;
  assign inactive_o      = inactive_ff;
  assign ready_o         = ready_ff;

  // Fixed fields never move, whatever the host programs
  a_struct_field: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    csd_o[127:120] == {sd_csd_pkg::STRUCT_VER, 6'h00})
    else $error("structure version field wrong");
  a_access_time: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    csd_o[119:104] == {sd_csd_pkg::ACCESS_TIME, sd_csd_pkg::ACCESS_CLKS})
    else $error("access time fields wrong");
  a_rate_code: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    prog_done |=> csd_o[103:96] == sd_csd_pkg::RATE_CODE)
    else $error("transfer rate changed by program");
  a_class_mask: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    csd_o[95:84] == sd_csd_pkg::CLASS_MASK)
    else $error("command class mask wrong");
  a_block_lens: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    csd_o[83:77] == {sd_csd_pkg::BLOCK_LEN, 3'h0} && csd_o[25:21] == {sd_csd_pkg::BLOCK_LEN, 1'h0})
    else $error("block length fields wrong");
  a_capacity_ro: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    ##1 csd_o[69:48] == $past(csd_o[69:48]) && csd_o[69:48] == CAPACITY)
    else $error("capacity field changed");
  a_erase_fields: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    csd_o[46:39] == {sd_csd_pkg::ERASE_ONE, sd_csd_pkg::SECTOR_SIZE})
    else $error("erase fields wrong");
  a_group_speed: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    csd_o[38:26] == {sd_csd_pkg::PROT_GRP_SIZE, sd_csd_pkg::PROT_GRP_EN, 2'h0,
                     sd_csd_pkg::SPEED_FACTOR})
    else $error("protect group or speed factor wrong");
  a_driver_lsb: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    csd_o[76] == sd_csd_pkg::DRIVER_STAGE && csd_o[0] == 1'h1)
    else $error("driver flag or end bit wrong");
  a_once_copy: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!$past(csd_o[14]) || csd_o[14]) && (!$past(csd_o[13]) || csd_o[13]))
    else $error("one-time bit cleared");
  a_tmp_written: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    prog_done && prog_ok |=> csd_o[12:1] == {$past(new_img[12]), 4'h0, $past(new_img[7:1])})
    else $error("writable fields not taken");
  a_reject_keeps: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    prog_done && !prog_ok |=> $stable(csd_o) && program_error_o)
    else $error("rejected program altered descriptor");
  a_rca_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    frame_done && frame_ok && cmd_index == sd_csd_pkg::CMD_SET_ADDR |=> rca_o == $past(arg_hi))
    else $error("address not loaded");
  a_inactive_stays: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    inactive_o |=> inactive_o && !sd_cmd_oe_o)
    else $error("inactive card left state");
  a_wake_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !ready_o |-> !sd_cmd_oe_o && state_ff == sd_csd_pkg::ST_WAKE)
    else $error("card answered before wake-up clocks");

endmodule
`default_nettype wire

/* File: logic/pin_sampler.sv */
// Two-flop synchronisers for link pins with edge detection on bit 0
`timescale 1ns/1ps
`default_nettype none
module pin_sampler #(
  parameter int W = 3
) (
  input  wire logic         clock_i,  // Block clock
  input  wire logic         rst_n_i,  // Async reset, active low
  input  wire logic [W-1:0] pin_i,    // Raw pins, bit 0 is the link clock
  output logic      [W-1:0] level_o,  // Synchronised levels
  output logic              rise_o,   // Bit 0 rose, one cycle
  output logic              fall_o    // Bit 0 fell, one cycle
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic         last_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
      last_ff <= 1'h0;
    end
    else
    begin
      meta_ff <= pin_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff[0];
    end
  end

  // Edges flagged in the same cycle as the synchronised level, against a copy one stage behind
  assign level_o = sync_ff;
  assign rise_o  = sync_ff[0] & ~last_ff;
  assign fall_o  = ~sync_ff[0] & last_ff;

endmodule
`default_nettype wire

/* File: logic/sd_csd_pkg.sv */
// Shared constants, states and descriptor layout for the card descriptor bank
package sd_csd_pkg;

  // Link-side counts, in rising edges of the host's card clock; the response counts falling edges
  localparam logic [7:0] WAKE_CYCLES    = 8'h4A;  // 74 idle clocks before first command
  localparam logic [7:0] CMD_FRAME_LAST = 8'h2F;  // Index of the 48th command bit
  localparam logic [7:0] RESP_BITS      = 8'h88;  // 136-bit long response
  localparam logic [7:0] DATA_LAST      = 8'h7F;  // Index of the 128th data bit

  // Command indices decoded by the bank
  localparam logic [5:0] CMD_SET_ADDR   = 6'h03;
  localparam logic [5:0] CMD_SEND_CSD   = 6'h09;
  localparam logic [5:0] CMD_INACTIVE   = 6'h0F;
  localparam logic [5:0] CMD_PROGRAM    = 6'h1B;

  // Fixed descriptor field values
  localparam logic [1:0]  STRUCT_VER    = 2'h1;
  localparam logic [7:0]  ACCESS_TIME   = 8'h0E;
  localparam logic [7:0]  ACCESS_CLKS   = 8'h00;
  localparam logic [7:0]  RATE_CODE     = 8'h32;
  localparam logic [11:0] CLASS_MASK    = 12'h5B5;
  localparam logic [3:0]  BLOCK_LEN     = 4'h9;
  localparam logic        DRIVER_STAGE  = 1'h0;
  localparam logic        ERASE_ONE     = 1'h1;
  localparam logic [6:0]  SECTOR_SIZE   = 7'h7F;
  localparam logic [6:0]  PROT_GRP_SIZE = 7'h00;
  localparam logic        PROT_GRP_EN   = 1'h0;
  localparam logic [2:0]  SPEED_FACTOR  = 3'h2;
  localparam logic [7:0]  RESP_HEADER   = 8'h3F;

  // Field positions of the host-writable bits and of the capacity field
  localparam int POS_COPY   = 14;
  localparam int POS_PERM   = 13;
  localparam int POS_TMP    = 12;
  localparam int POS_CRC_HI = 7;
  localparam int POS_CRC_LO = 1;
  localparam int POS_CAP_HI = 69;
  localparam int POS_CAP_LO = 48;

  // Values after reset
  localparam logic        RESET_COPY = 1'h0;
  localparam logic        RESET_PERM = 1'h0;
  localparam logic        RESET_TMP  = 1'h0;
  localparam logic [6:0]  RESET_CRC  = 7'h00;
  localparam logic [15:0] RESET_RCA  = 16'h0000;

  // Bits a program command may change: copy, permanent, temporary, checksum
  localparam logic [127:0] WR_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_70FE;

  // Link state machine, one-hot
  typedef enum logic [6:0] {
    ST_WAKE = 7'h01,
    ST_IDLE = 7'h02,
    ST_CMD  = 7'h04,
    ST_RESP = 7'h08,
    ST_DWAIT = 7'h10,
    ST_DATA = 7'h20,
    ST_DEAD = 7'h40
  } link_state_e;

  // Full 128-bit descriptor image from the few stored fields
  function automatic logic [127:0] build_csd(input logic [21:0] cap,
                                             input logic        copy,
                                             input logic        perm,
                                             input logic        tmp,
                                             input logic [6:0]  crc);
    build_csd = {STRUCT_VER, 6'h00, ACCESS_TIME, ACCESS_CLKS, RATE_CODE, CLASS_MASK,
                 BLOCK_LEN, 3'h0, DRIVER_STAGE, 6'h00, cap, 1'h0, ERASE_ONE,
                 SECTOR_SIZE, PROT_GRP_SIZE, PROT_GRP_EN, 2'h0, SPEED_FACTOR,
                 BLOCK_LEN, 1'h0, 5'h00, 1'h0, copy, perm, tmp, 2'h0, 2'h0,
                 crc, 1'h1};
  endfunction

endpackage
